// [logic/attc_pkg.sv]
package attc_pkg;

  // Register offsets
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_RETRIES = 8'h08;
  localparam logic [7:0] ADDR_LINK_ENH = 8'hf4;

  // Link enhancement control fields
  localparam int THR_LSB = 12;
  localparam int MPEG_BIT = 10;
  localparam int DV_BIT = 8;
  localparam int PRIO_BIT = 7;
  localparam logic [31:0] LINK_ENH_RESET = 32'h0000_1000;
  localparam logic [1:0] THR_RESET = 2'h1;

  // Status fields
  localparam int ST_UNDERRUN = 0;
  localparam int ST_RETRY = 1;
  localparam int ST_SENDING = 2;
  localparam int ST_SF = 3;
  localparam int ST_COMPLETE = 4;

  // Retries register
  localparam int RETRIES_W = 12;
  localparam logic [RETRIES_W-1:0] RETRIES_RESET = 12'h000;

  // Threshold select encodings and fill levels in bytes
  localparam logic [1:0] THR_SEL_SF = 2'h0;
  localparam logic [1:0] THR_SEL_1K7 = 2'h1;
  localparam logic [1:0] THR_SEL_1K = 2'h2;
  localparam int LEVEL_W = 12;
  localparam logic [LEVEL_W-1:0] THR_2K = 12'h800;
  localparam logic [LEVEL_W-1:0] THR_1K7 = 12'h6cc;
  localparam logic [LEVEL_W-1:0] THR_1K = 12'h400;
  localparam logic [LEVEL_W-1:0] THR_512 = 12'h200;

  // Stream format codes
  localparam int FMT_W = 6;
  localparam logic [FMT_W-1:0] FMT_MPEG = 6'h20;
  localparam logic [FMT_W-1:0] FMT_DV = 6'h00;

  // Count of end-of-packet markers held in the FIFO
  localparam int EOP_CNT_W = 6;

  typedef enum logic [3:0] {
    S_IDLE = 4'h1,
    S_WAIT = 4'h2,
    S_SEND = 4'h4,
    S_RESEND = 4'h8
  } attc_state_t;

endpackage : attc_pkg

// [logic/attc_pkt_if.sv]
`timescale 1ns/1ps
interface attc_pkt_if;
  logic eop_wr;
  logic pkt_done;
  logic complete_avail;

  modport counter (
    input eop_wr,
    input pkt_done,
    output complete_avail
  );

  modport ctrl (
    output eop_wr,
    output pkt_done,
    input complete_avail
  );
endinterface : attc_pkt_if

// [logic/attc_eop_count.sv]
`timescale 1ns/1ps
module attc_eop_count (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Packet markers
  attc_pkt_if.counter pkt
);

  typedef struct packed {
    logic [attc_pkg::EOP_CNT_W-1:0] cnt;
  } attc_cnt_st_t;

  attc_cnt_st_t st_r;
  attc_cnt_st_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    // Marker written and packet retired in one cycle cancel out
    if (pkt.eop_wr && !pkt.pkt_done) begin
      st_nxt.cnt = st_r.cnt + 1'b1;
    end else if (!pkt.eop_wr && pkt.pkt_done && st_r.cnt != '0) begin
      st_nxt.cnt = st_r.cnt - 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pkt.complete_avail = (st_r.cnt != '0);

endmodule : attc_eop_count

// [logic/attc_stamp_sel.sv]
`timescale 1ns/1ps
module attc_stamp_sel (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Stream and enables
  input wire logic [attc_pkg::FMT_W-1:0] stream_format_code,
  input wire logic mpeg_stamp_fix_en,
  input wire logic dv_stamp_fix_en,
  // Result
  output logic stamp_fix_apply
);

  typedef struct packed {
    logic apply;
  } attc_stamp_st_t;

  attc_stamp_st_t st_r;
  attc_stamp_st_t st_nxt;

  always_comb begin
    st_nxt.apply =
      (mpeg_stamp_fix_en &&
       stream_format_code == attc_pkg::FMT_MPEG) ||
      (dv_stamp_fix_en &&
       stream_format_code == attc_pkg::FMT_DV);
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign stamp_fix_apply = st_r.apply;

endmodule : attc_stamp_sel

// [logic/attc_ctrl.sv]
// Chosen here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
module attc_ctrl (
  // Clock and resets
  input wire logic mclk,
  input wire logic nrst,
  input wire logic global_reset_pin_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // FIFO fill side
  input wire logic [attc_pkg::LEVEL_W-1:0] fifo_level,
  input wire logic fifo_empty,
  input wire logic fifo_eop_wr,
  // Physical layer side
  output logic tx_start,
  output logic tx_abort,
  output logic tx_sending,
  input wire logic tx_done,
  input wire logic tx_retry,
  output logic priority_req_en,
  // Isochronous stamp fix
  input wire logic [attc_pkg::FMT_W-1:0] stream_format_code,
  output logic mpeg_stamp_fix_en,
  output logic dv_stamp_fix_en,
  output logic stamp_fix_apply,
  // Status
  output logic sf_active
);

  // Fields kept across warm resets
  typedef struct packed {
    logic [1:0] thr_sel;
    logic mpeg_en;
    logic dv_en;
    logic prio_en;
  } attc_cfg_t;

  typedef struct packed {
    attc_pkg::attc_state_t state;
    logic [attc_pkg::LEVEL_W-1:0] thr_cur;
    logic sf_cur;
    logic underrun_seen;
    logic retry_pend;
    logic [attc_pkg::RETRIES_W-1:0] retries;
    logic start;
    logic abort;
    logic done;
    logic [31:0] rdata;
  } attc_st_t;

  attc_cfg_t cfg_r;
  attc_cfg_t cfg_nxt;
  attc_st_t st_r;
  attc_st_t st_nxt;

  logic warm_rst_n;
  logic wr_enh;
  logic wr_ret;
  logic wr_stat;
  logic sf_force;
  logic start_ok;
  logic underrun;
  logic [attc_pkg::LEVEL_W-1:0] thr_sel_bytes;
  logic [31:0] enh_view;
  logic [31:0] stat_view;

  attc_pkt_if pkt ();

  // Global reset also clears everything a warm reset clears
  assign warm_rst_n = nrst & global_reset_pin_n;

  attc_eop_count u_eop_count (
    .mclk(mclk),
    .rst_n(warm_rst_n),
    .pkt(pkt.counter)
  );

  attc_stamp_sel u_stamp_sel (
    .mclk(mclk),
    .rst_n(warm_rst_n),
    .stream_format_code(stream_format_code),
    .mpeg_stamp_fix_en(cfg_r.mpeg_en),
    .dv_stamp_fix_en(cfg_r.dv_en),
    .stamp_fix_apply(stamp_fix_apply)
  );

  assign pkt.eop_wr = fifo_eop_wr;
  assign pkt.pkt_done = st_r.done;

  assign wr_enh = reg_wr && reg_addr == attc_pkg::ADDR_LINK_ENH;
  assign wr_ret = reg_wr && reg_addr == attc_pkg::ADDR_RETRIES;
  assign wr_stat = reg_wr && reg_addr == attc_pkg::ADDR_STATUS;

  // Fill level for the programmed select
  always_comb begin
    case (cfg_r.thr_sel)
      attc_pkg::THR_SEL_SF: thr_sel_bytes = attc_pkg::THR_2K;
      attc_pkg::THR_SEL_1K7: thr_sel_bytes = attc_pkg::THR_1K7;
      attc_pkg::THR_SEL_1K: thr_sel_bytes = attc_pkg::THR_1K;
      default: thr_sel_bytes = attc_pkg::THR_512;
    endcase
  end

  // Store-and-forward whenever anything calls for it
  assign sf_force = cfg_r.thr_sel == attc_pkg::THR_SEL_SF ||
                    st_r.underrun_seen ||
                    st_r.retries == '0;

  // Cut-through: level reached or whole packet in; otherwise marker only
  assign start_ok = pkt.complete_avail ||
                    (!st_r.sf_cur && fifo_level >= st_r.thr_cur);

  // FIFO ran dry mid-packet with the marker not yet written
  assign underrun = fifo_empty && !pkt.complete_avail;

  assign enh_view = {
    18'h0,
    cfg_r.thr_sel,
    1'b0,
    cfg_r.mpeg_en,
    1'b0,
    cfg_r.dv_en,
    cfg_r.prio_en,
    7'h0
  };

  assign stat_view = {
    27'h0,
    pkt.complete_avail,
    st_r.sf_cur,
    st_r.state == attc_pkg::S_SEND,
    st_r.retry_pend,
    st_r.underrun_seen
  };

  always_comb begin
    cfg_nxt = cfg_r;
    if (wr_enh) begin
      // Reserved positions have no storage
      cfg_nxt.thr_sel = reg_wdata[attc_pkg::THR_LSB+:2];
      cfg_nxt.mpeg_en = reg_wdata[attc_pkg::MPEG_BIT];
      cfg_nxt.dv_en = reg_wdata[attc_pkg::DV_BIT];
      cfg_nxt.prio_en = reg_wdata[attc_pkg::PRIO_BIT];
    end
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.start = 1'b0;
    st_nxt.abort = 1'b0;
    st_nxt.done = 1'b0;
    st_nxt.rdata = 32'h0000_0000;

    if (wr_ret) begin
      st_nxt.retries = reg_wdata[attc_pkg::RETRIES_W-1:0];
    end
    // Write one to clear; a new underrun in the same cycle wins
    if (wr_stat && reg_wdata[attc_pkg::ST_UNDERRUN]) begin
      st_nxt.underrun_seen = 1'b0;
    end

    case (st_r.state)
      attc_pkg::S_IDLE: begin
        // Marker of the packet just retired is still counted this cycle
        if ((!fifo_empty || pkt.complete_avail) && !st_r.done) begin
          // Select latched once per packet
          st_nxt.thr_cur = sf_force ? attc_pkg::THR_2K
                                    : thr_sel_bytes;
          st_nxt.sf_cur = sf_force;
          st_nxt.state = attc_pkg::S_WAIT;
        end
      end
      attc_pkg::S_WAIT: begin
        if (start_ok) begin
          st_nxt.start = 1'b1;
          st_nxt.state = attc_pkg::S_SEND;
        end
      end
      attc_pkg::S_SEND: begin
        if (tx_done) begin
          st_nxt.done = 1'b1;
          st_nxt.retry_pend = 1'b0;
          st_nxt.state = attc_pkg::S_IDLE;
        end else if (tx_retry) begin
          st_nxt.retry_pend = 1'b1;
          st_nxt.sf_cur = 1'b1;
          st_nxt.thr_cur = attc_pkg::THR_2K;
          st_nxt.state = attc_pkg::S_RESEND;
        end else if (underrun) begin
          st_nxt.abort = 1'b1;
          st_nxt.underrun_seen = 1'b1;
          st_nxt.retry_pend = 1'b1;
          st_nxt.sf_cur = 1'b1;
          st_nxt.thr_cur = attc_pkg::THR_2K;
          st_nxt.state = attc_pkg::S_RESEND;
        end
      end
      attc_pkg::S_RESEND: begin
        // Resend only with the whole packet buffered
        if (pkt.complete_avail) begin
          st_nxt.start = 1'b1;
          st_nxt.state = attc_pkg::S_SEND;
        end
      end
      default: begin
        st_nxt.state = attc_pkg::S_IDLE;
      end
    endcase

    if (reg_rd) begin
      case (reg_addr)
        attc_pkg::ADDR_LINK_ENH: st_nxt.rdata = enh_view;
        attc_pkg::ADDR_RETRIES:
          st_nxt.rdata = {20'h0, st_r.retries};
        attc_pkg::ADDR_STATUS: st_nxt.rdata = stat_view;
        default: st_nxt.rdata = 32'h0000_0000;
      endcase
    end
  end

  // Only the global reset touches these
  always_ff @(posedge mclk or negedge global_reset_pin_n) begin
    if (!global_reset_pin_n) begin
      cfg_r.thr_sel <= attc_pkg::THR_RESET;
      cfg_r.mpeg_en <= 1'b0;
      cfg_r.dv_en <= 1'b0;
      cfg_r.prio_en <= 1'b0;
    end else begin
      cfg_r <= cfg_nxt;
    end
  end

  always_ff @(posedge mclk or negedge warm_rst_n) begin
    if (!warm_rst_n) begin
      st_r.state <= attc_pkg::S_IDLE;
      st_r.thr_cur <= attc_pkg::THR_2K;
      st_r.sf_cur <= 1'b1;
      st_r.underrun_seen <= 1'b0;
      st_r.retry_pend <= 1'b0;
      st_r.retries <= attc_pkg::RETRIES_RESET;
      st_r.start <= 1'b0;
      st_r.abort <= 1'b0;
      st_r.done <= 1'b0;
      st_r.rdata <= 32'h0000_0000;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata = st_r.rdata;
  assign tx_start = st_r.start;
  assign tx_abort = st_r.abort;
  assign tx_sending = st_r.state == attc_pkg::S_SEND;
  assign sf_active = st_r.sf_cur;
  assign priority_req_en = cfg_r.prio_en;
  assign mpeg_stamp_fix_en = cfg_r.mpeg_en;
  assign dv_stamp_fix_en = cfg_r.dv_en;

endmodule : attc_ctrl

// [verif/attc_ctrl_asserts.sv]
`timescale 1ns/1ps
module attc_ctrl_asserts (
  // Clock and resets
  input wire logic mclk,
  input wire logic nrst,
  input wire logic global_reset_pin_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // Transmit
  input wire logic fifo_empty,
  input wire logic tx_start,
  input wire logic tx_abort,
  input wire logic tx_sending,
  input wire logic tx_done,
  input wire logic sf_active,
  // Enables and stamp fix
  input wire logic priority_req_en,
  input wire logic [attc_pkg::FMT_W-1:0] stream_format_code,
  input wire logic mpeg_stamp_fix_en,
  input wire logic dv_stamp_fix_en,
  input wire logic stamp_fix_apply
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst || !global_reset_pin_n);
  logic fix_w;
  logic enh_rd_w;
  assign fix_w = (mpeg_stamp_fix_en
    && stream_format_code == attc_pkg::FMT_MPEG)
    || (dv_stamp_fix_en && stream_format_code == attc_pkg::FMT_DV);
  assign enh_rd_w = reg_rd && reg_addr == attc_pkg::ADDR_LINK_ENH;

  rd_idle_a: assert property (
    !$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside its slot");
  rsvd_zero_a: assert property (
    $past(enh_rd_w) |-> (reg_rdata & 32'hffff_ca7f) == 32'h0)
    else $error("reserved control bits read nonzero");
  en_mirror_a: assert property (
    $past(enh_rd_w) |-> reg_rdata[10] == mpeg_stamp_fix_en
    && reg_rdata[8] == dv_stamp_fix_en && reg_rdata[7] == priority_req_en)
    else $error("enable outputs differ from control word");
  stamp_on_a: assert property (
    fix_w |=> stamp_fix_apply)
    else $error("stamp fix not applied");
  stamp_off_a: assert property (
    !fix_w |=> !stamp_fix_apply)
    else $error("stamp fix applied to wrong stream");
  start_pulse_a: assert property (
    tx_start |-> tx_sending && !$past(tx_sending) ##1 !tx_start)
    else $error("bad start pulse");
  abort_cause_a: assert property (
    tx_abort |-> $past(tx_sending) && $past(fifo_empty) && sf_active)
    else $error("abort without underrun");
  done_ends_a: assert property (
    tx_sending && tx_done |=> !tx_sending ##1 !tx_start)
    else $error("send not ended by done");
endmodule : attc_ctrl_asserts

bind attc_ctrl attc_ctrl_asserts chk_u (.mclk, .nrst, .global_reset_pin_n,
  .reg_addr, .reg_rd, .reg_rdata, .fifo_empty, .tx_start, .tx_abort,
  .tx_sending, .tx_done, .sf_active, .priority_req_en, .stream_format_code,
  .mpeg_stamp_fix_en, .dv_stamp_fix_en, .stamp_fix_apply);

// [verif/attc_phy_model.sv]
`timescale 1ns/1ps
module attc_phy_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Link side
  input wire logic tx_start,
  input wire logic tx_abort,
  // Bench controls
  input wire logic [3:0] lat,
  input wire logic bad,
  // Answers
  output logic tx_done,
  output logic tx_retry
);
  logic [3:0] cnt_r;
  logic busy_r;
  logic bad_r;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= 4'h0;
      busy_r <= 1'b0;
      bad_r <= 1'b0;
      tx_done <= 1'b0;
      tx_retry <= 1'b0;
    end else begin
      tx_done <= busy_r && cnt_r == 4'h0 && !bad_r;
      tx_retry <= busy_r && cnt_r == 4'h0 && bad_r;
      if (tx_start) begin
        busy_r <= 1'b1;
        cnt_r <= lat;
        bad_r <= bad;
      end else if (tx_abort || cnt_r == 4'h0) begin
        busy_r <= 1'b0;
      end else begin
        cnt_r <= cnt_r - 4'h1;
      end
    end
  end
endmodule : attc_phy_model

// [verif/attc_ctrl_tb.sv]
`timescale 1ns/1ps
module attc_ctrl_tb;
  logic mclk, nrst, global_reset_pin_n, reg_wr, reg_rd, bad;
  logic fifo_empty, fifo_eop_wr, tx_start, tx_abort, tx_sending;
  logic tx_done, tx_retry, priority_req_en, mpeg_stamp_fix_en;
  logic dv_stamp_fix_en, stamp_fix_apply, sf_active;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [attc_pkg::LEVEL_W-1:0] fifo_level;
  logic [attc_pkg::FMT_W-1:0] stream_format_code;
  logic [3:0] lat;
  logic [attc_pkg::LEVEL_W-1:0] thr [4] = '{attc_pkg::THR_2K,
    attc_pkg::THR_1K7, attc_pkg::THR_1K, attc_pkg::THR_512};
  int num_errors = 0;
  int comparisons = 0;
  int cycles = 0;

  attc_ctrl dut_u (.mclk, .nrst, .global_reset_pin_n, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .fifo_level, .fifo_empty, .fifo_eop_wr,
    .tx_start, .tx_abort, .tx_sending, .tx_done, .tx_retry,
    .priority_req_en, .stream_format_code, .mpeg_stamp_fix_en,
    .dv_stamp_fix_en, .stamp_fix_apply, .sf_active);
  attc_phy_model phy_u (.mclk, .nrst, .tx_start, .tx_abort, .lat, .bad,
    .tx_done, .tx_retry);

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Sent data has left the FIFO
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (tx_done === 1'b1) begin
      fifo_empty <= 1'b1;
      fifo_level <= '0;
    end
    if (cycles == 3000) begin
      num_errors++;
      final_report();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    @(posedge mclk);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] m,
    input logic [31:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    // Read data stand for the one cycle after the strobe
    @(negedge mclk);
    chk(reg_rdata & m, e);
    @(posedge mclk);
  endtask : rd

  // Watch n edges for a start or abort pulse
  task automatic watch(input int n, input logic ab, input logic exp);
    logic got;
    got = 1'b0;
    repeat (n) begin
      @(posedge mclk);
      got = got | (ab ? tx_abort === 1'b1 : tx_start === 1'b1);
    end
    chk(got, exp);
  endtask : watch

  task automatic drain;
    for (int i = 0; i < 40 && tx_sending !== 1'b0; i++)
      @(posedge mclk);
    chk(tx_sending, 1'b0);
    @(posedge mclk);
  endtask : drain

  task automatic fill(input logic [attc_pkg::LEVEL_W-1:0] l);
    fifo_empty <= 1'b0;
    fifo_level <= l;
  endtask : fill

  task automatic cut(input logic [attc_pkg::LEVEL_W-1:0] l);
    fill(l - 12'h1);
    watch(8, 1'b0, 1'b0);
    fifo_level <= l;
    watch(4, 1'b0, 1'b1);
    chk(sf_active, 1'b0);
    drain();
  endtask : cut

  task automatic sf(input logic [attc_pkg::LEVEL_W-1:0] l);
    fill(l);
    watch(8, 1'b0, 1'b0);
    fifo_eop_wr <= 1'b1;
    @(posedge mclk);
    fifo_eop_wr <= 1'b0;
    watch(4, 1'b0, 1'b1);
    chk(sf_active, 1'b1);
    drain();
  endtask : sf

  task automatic stamp(input logic [attc_pkg::FMT_W-1:0] f, input logic e);
    stream_format_code <= f;
    repeat (2) @(posedge mclk);
    chk(stamp_fix_apply, e);
  endtask : stamp

  task automatic final_report;
    $display("comparisons=%0d num_errors=%0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : final_report

  initial begin
    {nrst, global_reset_pin_n, reg_wr, reg_rd, fifo_eop_wr, bad} = '0;
    {reg_addr, reg_wdata, fifo_level, stream_format_code} = '0;
    fifo_empty = 1'b1;
    lat = 4'h2;
    repeat (3) @(posedge mclk);
    nrst <= 1'b1;
    global_reset_pin_n <= 1'b1;
    rd(attc_pkg::ADDR_LINK_ENH, '1, 32'h0000_1000);
    rd(attc_pkg::ADDR_RETRIES, '1, 32'h0);
    rd(8'h44, '1, 32'h0);
    wr(attc_pkg::ADDR_LINK_ENH, '1);
    rd(attc_pkg::ADDR_LINK_ENH, '1, 32'h0000_3580);
    chk({priority_req_en, mpeg_stamp_fix_en, dv_stamp_fix_en}, 3'h7);
    stamp(6'h20, 1'b1);
    stamp(6'h00, 1'b1);
    stamp(6'h01, 1'b0);
    wr(attc_pkg::ADDR_LINK_ENH, 32'h0000_0400);
    stamp(6'h00, 1'b0);
    nrst <= 1'b0;
    @(posedge mclk);
    nrst <= 1'b1;
    rd(attc_pkg::ADDR_LINK_ENH, '1, 32'h0000_0400);
    global_reset_pin_n <= 1'b0;
    @(posedge mclk);
    global_reset_pin_n <= 1'b1;
    rd(attc_pkg::ADDR_LINK_ENH, '1, 32'h0000_1000);
    wr(attc_pkg::ADDR_LINK_ENH, 32'h0000_3000);
    sf(12'hfff);
    wr(attc_pkg::ADDR_RETRIES, 32'h3);
    wr(attc_pkg::ADDR_LINK_ENH, 32'h0);
    sf(12'hfff);
    for (int s = 1; s < 4; s++) begin
      wr(attc_pkg::ADDR_LINK_ENH, 32'(s) << attc_pkg::THR_LSB);
      cut(thr[s]);
    end
    // Select change while waiting applies to later packets
    fill(12'h100);
    repeat (2) @(posedge mclk);
    wr(attc_pkg::ADDR_LINK_ENH, 32'h0000_2000);
    fifo_level <= attc_pkg::THR_512;
    watch(4, 1'b0, 1'b1);
    drain();
    wr(attc_pkg::ADDR_LINK_ENH, 32'h0000_3000);
    lat <= 4'hf;
    fill(attc_pkg::THR_512);
    watch(4, 1'b0, 1'b1);
    fifo_empty <= 1'b1;
    fifo_level <= '0;
    watch(3, 1'b1, 1'b1);
    chk(sf_active, 1'b1);
    rd(attc_pkg::ADDR_STATUS, 32'h1, 32'h1);
    lat <= 4'h2;
    sf(12'h300);
    wr(attc_pkg::ADDR_STATUS, 32'h1);
    cut(attc_pkg::THR_512);
    bad <= 1'b1;
    fill(attc_pkg::THR_512);
    watch(4, 1'b0, 1'b1);
    bad <= 1'b0;
    sf(attc_pkg::THR_512);
    final_report();
  end
endmodule : attc_ctrl_tb
